/* File: hdl/sdc_commutator.sv */
// sensor data commutator: staging counter, hv converter handshake, write strobes
//
// Function
// - staging register is seven-bit counter, first bit most significant
// - conversion start clears staging counter before burst pulses count
// - sectors 3,5,7 with flux block low: burst counts until sector end
// - sectors 2,4,6: burst counts with flux block low, flux pulse clears, remainder is flux value
// - sector 10: start clears, bursts count, conversion done clears again
// - on sequence completion the seven staged bits go to buffer storage
// - hv start sets converter flop; comparator flip fires done pulse in sector 10
// - phase-one pulse clears converter flop so ramp recharges
// - hv polarity selects ion or electron input path
// - azimuth mode strobes at phase two of selected sectors
// - azimuth mode extra strobes at phase one in sectors 66, 72, 78
// - extra strobes decoded from upper bits, sectors 64-79, even only
// - polar mode strobes at phase two of sectors 2-7 and 10
// - polar mode extra strobes at phase one of sectors 2 and 10
// - buffer empty presets both divide-by-three stages
// - hv advance steps divider; second stage setting re-toggles first
// - max-flux strobes phase two sectors 2,3, and sector 1 when first set only
// - mode strobes ORed; suppressed by hv zero, write inhibit or full fifo
`timescale 1ns/1ns
module sdc_commutator (
  // clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                rst_in,
  // instrument timing
  input  wire sdc_pkg::sdc_timing_t timing_in,
  // high-voltage converter
  input  wire sdc_pkg::sdc_hv_t    hv_in,
  output      logic                ion_path_en_out,
  output      logic                electron_path_en_out,
  output      logic                ramp_active_out,
  output      logic                hv_conversion_done_out,
  // buffer storage side
  output      logic                write_strobe_out,
  output      logic [6:0]          staged_bits_out,
  output      logic                buf_valid_out,
  input  wire logic                buf_ready_in,
  output      logic [6:0]          buf_data_out,
  output      logic                fifo_full_out,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output      logic [31:0]         prdata,
  output      logic                pready,
  output      logic                pslverr
);
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [6:0]  stage;
    logic [6:0]  staged;
    logic        conv_ff;
    logic        cmp_d;
    logic        done;
    logic        div_q1;
    logic        div_q2;
    logic        strobe;
    logic        push;
    logic [31:0] rdata;
    logic        overflow;
  } sdc_state_t;

  sdc_state_t       st_reg;
  sdc_state_t       st_next;
  sdc_pkg::sdc_mode_t mode;
  logic [6:0]       sec;
  logic             sec_246;
  logic             sec_357;
  logic             sec_10;
  logic             done_pulse;
  logic             sector_odd_bit;
  logic             az_extra;
  logic             az_wp;
  logic             polar_wp;
  logic             maxflux_wp;
  logic             fifo_ready;
  logic [3:0]       fifo_level;
  logic             apb_wr;
  logic             apb_rd;

  ////////////////////////////////////////////////////////////////////////////
  // sector decodes
  assign sec     = timing_in.sector;
  assign sec_10  = sec == sdc_pkg::SEC_10;
  assign sec_246 = (sec >= sdc_pkg::SEC_2) && (sec <= sdc_pkg::SEC_7) && !sec[sdc_pkg::ODD_BIT];
  assign sec_357 = (sec >= sdc_pkg::SEC_3) && (sec <= sdc_pkg::SEC_7) && sec[sdc_pkg::ODD_BIT];
  assign sector_odd_bit = sec[sdc_pkg::ODD_BIT];

  // one mode at a time, azimuth first
  always_comb
  begin
    if (st_reg.ctrl[sdc_pkg::CTRL_AZ_BIT])
      mode = sdc_pkg::SDC_MODE_AZ;
    else if (st_reg.ctrl[sdc_pkg::CTRL_PLR_BIT])
      mode = sdc_pkg::SDC_MODE_POLAR;
    else if (st_reg.ctrl[sdc_pkg::CTRL_MXF_BIT])
      mode = sdc_pkg::SDC_MODE_MAXFLUX;
    else
      mode = sdc_pkg::SDC_MODE_NONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter done: falling comparator edge qualified by sector 10
  assign done_pulse = st_reg.conv_ff && st_reg.cmp_d && !hv_in.comparator && sec_10;

  // input path select
  assign ion_path_en_out      = !hv_in.hv_polarity;
  assign electron_path_en_out = hv_in.hv_polarity;

  ////////////////////////////////////////////////////////////////////////////
  // extra azimuth strobes: groups a/b/c within 64-79, even sectors
  assign az_extra = (sec[6:4] == sdc_pkg::SEC_HI_64_79) && !sector_odd_bit
                    && ((sec[3:1] == sdc_pkg::AZ_GRP_A) || (sec[3:1] == sdc_pkg::AZ_GRP_B)
                        || (sec[3:1] == sdc_pkg::AZ_GRP_C));
  // mode write pulses
  always_comb
  begin
    az_wp      = 1'b0;
    polar_wp   = 1'b0;
    maxflux_wp = 1'b0;
    case (mode)
      sdc_pkg::SDC_MODE_AZ:
      begin
        az_wp = (timing_in.phase_two && timing_in.az_selected)
                || (timing_in.phase_one && az_extra);
      end
      sdc_pkg::SDC_MODE_POLAR:
      begin
        polar_wp = (timing_in.phase_two && (((sec >= sdc_pkg::SEC_2) && (sec <= sdc_pkg::SEC_7)) || sec_10))
                   || (timing_in.phase_one && ((sec == sdc_pkg::SEC_2) || sec_10));
      end
      sdc_pkg::SDC_MODE_MAXFLUX:
      begin
        maxflux_wp = timing_in.phase_two && ((sec == sdc_pkg::SEC_2) || (sec == sdc_pkg::SEC_3)
                     || (st_reg.div_q1 && !st_reg.div_q2 && (sec == sdc_pkg::SEC_1)));
      end
      default:
      begin
        az_wp = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_next        = st_reg;
    st_next.cmp_d  = hv_in.comparator;
    st_next.done   = done_pulse;
    st_next.push   = 1'b0;
    st_next.rdata  = '0;
    // staging counter, clears take priority over counting
    if (timing_in.conv_start)
      st_next.stage = sdc_pkg::STAGE_RESET;
    else if (sec_246 && timing_in.flux_pulse)
      st_next.stage = sdc_pkg::STAGE_RESET;
    else if (sec_10 && done_pulse)
      st_next.stage = sdc_pkg::STAGE_RESET;
    else if (timing_in.burst && ((sec_357 && !timing_in.flux_block) || (sec_246 && !timing_in.flux_block) || sec_10))
      st_next.stage = st_reg.stage + 7'h01;
    // sequence completion hands staged bits to the buffer
    if (timing_in.sector_end && (sec_246 || sec_357 || sec_10))
    begin
      st_next.staged = st_reg.stage;
      st_next.push   = 1'b1;
    end
    // converter flop: phase one clear wins, start sets, comparator drop ends ramp
    if (timing_in.phase_one)
      st_next.conv_ff = 1'b0;
    else if (hv_in.hv_conversion_start)
      st_next.conv_ff = 1'b1;
    else if (st_reg.cmp_d && !hv_in.comparator)
      st_next.conv_ff = 1'b0;
    // divide by three
    if (hv_in.buffer_empty)
    begin
      st_next.div_q1 = 1'b1;
      st_next.div_q2 = 1'b1;
    end
    else if (hv_in.hv_step_advance)
    begin
      if (st_reg.div_q1)
      begin
        st_next.div_q2 = !st_reg.div_q2;
        st_next.div_q1 = !st_reg.div_q2; // second stage setting re-toggles first
      end
      else
        st_next.div_q1 = 1'b1;
    end
    // composite strobe
    st_next.strobe = (az_wp || polar_wp || maxflux_wp) && !hv_in.hv_zero
                     && !st_reg.ctrl[sdc_pkg::CTRL_INH_BIT] && fifo_ready;
    if (st_reg.push && !fifo_ready)
      st_next.overflow = 1'b1;
    // apb access
    if (apb_wr && (paddr == sdc_pkg::CTRL_OFS))
      st_next.ctrl = pwdata[3:0];
    if (apb_wr && (paddr == sdc_pkg::STATUS_OFS) && pwdata[0] && !(st_reg.push && !fifo_ready))
      st_next.overflow = 1'b0;
    if (apb_rd)
    begin
      case (paddr)
        sdc_pkg::CTRL_OFS:   st_next.rdata = {28'h0000000, st_reg.ctrl};
        sdc_pkg::STATUS_OFS: st_next.rdata = {24'h000000, fifo_level, st_reg.div_q2, st_reg.div_q1,
                                              st_reg.conv_ff, st_reg.overflow};
        sdc_pkg::STAGE_OFS:  st_next.rdata = {18'h00000, st_reg.staged, st_reg.stage};
        sdc_pkg::FIFO_OFS:   st_next.rdata = {24'h000000, buf_valid_out, buf_data_out};
        default:             st_next.rdata = '0;
      endcase
    end
  end

  // apb strobes: read captured in setup, write lands with pready in access
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && (paddr > sdc_pkg::FIFO_OFS);
  assign prdata  = st_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg      <= '0;
      st_reg.ctrl <= sdc_pkg::CTRL_RESET;
    end
    else
      st_reg <= st_next;
  end

  // outputs
  assign ramp_active_out        = st_reg.conv_ff;
  assign hv_conversion_done_out = st_reg.done;
  assign write_strobe_out       = st_reg.strobe;
  assign staged_bits_out        = st_reg.staged;

  ////////////////////////////////////////////////////////////////////////////
  // staged word buffer toward core storage
  sdc_fifo #(
    .W (sdc_pkg::FIFO_W),
    .D (sdc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (ref_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (st_reg.push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (st_reg.staged),
    .out_valid_out (buf_valid_out),
    .out_ready_in  (buf_ready_in),
    .out_data_out  (buf_data_out),
    .level_out     (fifo_level)
  );
  assign fifo_full_out = !fifo_ready;
endmodule // sdc_commutator

/* File: hdl/sdc_pkg.sv */
// package with constants and carrier types of the sensor data commutator
package sdc_pkg;
  localparam int          STAGE_W       = 7;
  localparam int          SECTOR_W      = 7;
  localparam int          FIFO_W        = 7;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          APB_AW        = 12;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam logic [11:0] STAGE_OFS     = 12'h008;
  localparam logic [11:0] FIFO_OFS      = 12'h00c;
  // control field positions
  localparam int          CTRL_AZ_BIT   = 0;
  localparam int          CTRL_PLR_BIT  = 1;
  localparam int          CTRL_MXF_BIT  = 2;
  localparam int          CTRL_INH_BIT  = 3;
  localparam logic [3:0]  CTRL_RESET    = 4'h0;
  localparam logic [6:0]  STAGE_RESET   = 7'h00;
  // sector decodes
  localparam logic [6:0]  SEC_1         = 7'h01;
  localparam logic [6:0]  SEC_2         = 7'h02;
  localparam logic [6:0]  SEC_3         = 7'h03;
  localparam logic [6:0]  SEC_7         = 7'h07;
  localparam logic [6:0]  SEC_10        = 7'h0a;
  localparam logic [2:0]  SEC_HI_64_79  = 3'h4;
  localparam logic [2:0]  AZ_GRP_A      = 3'h1;
  localparam logic [2:0]  AZ_GRP_B      = 3'h4;
  localparam logic [2:0]  AZ_GRP_C      = 3'h7;
  localparam int          ODD_BIT       = 0;

  // scan mode selection
  typedef enum logic [1:0] {SDC_MODE_NONE, SDC_MODE_AZ, SDC_MODE_POLAR, SDC_MODE_MAXFLUX} sdc_mode_t;

  // timing pulses from the instrument
  typedef struct packed {
    logic       phase_one;
    logic       phase_two;
    logic       conv_start;
    logic       burst;
    logic       flux_pulse;
    logic       flux_block;
    logic       sector_end;
    logic [6:0] sector;
    logic       az_selected;
  } sdc_timing_t;

  // high-voltage converter side signals
  typedef struct packed {
    logic hv_conversion_start;
    logic comparator;
    logic hv_polarity;
    logic hv_zero;
    logic hv_step_advance;
    logic buffer_empty;
  } sdc_hv_t;
endpackage

/* File: hdl/sdc_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module sdc_fifo #(
  parameter int W = 7,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // fill side
  input  wire logic         in_valid_in,
  output      logic         in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // drain side
  output      logic         out_valid_out,
  input  wire logic         out_ready_in,
  output      logic [W-1:0] out_data_out,
  output      logic [$clog2(D):0] level_out
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } sdcf_state_t;
  sdcf_state_t st_reg;
  sdcf_state_t st_next;
  logic push;
  logic pop;

  // handshake terms
  assign in_ready_out  = st_reg.cnt < (AW+1)'(D);
  assign out_valid_out = st_reg.cnt != '0;
  assign out_data_out  = st_reg.mem[st_reg.rp];
  assign level_out     = st_reg.cnt;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // next state
  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wp] = in_data_in;
      st_next.wp             = (st_reg.wp == AW'(D-1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop)
      st_next.rp = (st_reg.rp == AW'(D-1)) ? '0 : st_reg.rp + 1'b1;
    if (push && !pop)
      st_next.cnt = st_reg.cnt + 1'b1;
    else if (pop && !push)
      st_next.cnt = st_reg.cnt - 1'b1;
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule // sdc_fifo

/* File: tb/sdc_buf_model.sv */
// buffer storage model taking words from the commutator fifo
`timescale 1ns/1ns
module sdc_buf_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // drain side
  input  wire logic       stall_in,
  input  wire logic       valid_in,
  input  wire logic [6:0] data_in,
  output      logic       ready_out,
  output      logic [6:0] last_out,
  output      int         count_out
);
  ////////////////////////////////////////
  // accept one word a cycle unless stalled
  assign ready_out = !stall_in;
  // keep the last word and a running count
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      last_out  <= 7'h00;
      count_out <= 0;
    end
    else if (valid_in && ready_out)
    begin
      last_out  <= data_in;
      count_out <= count_out + 1;
    end
endmodule // sdc_buf_model

/* File: tb/sdc_commutator_props.sv */
// port assertions for the sensor data commutator
`timescale 1ns/1ns
module sdc_commutator_props (
  // clock and reset
  input wire logic                 ref_clk_in,
  input wire logic                 rst_in,
  // stimulus side
  input wire sdc_pkg::sdc_timing_t timing_in,
  input wire sdc_pkg::sdc_hv_t     hv_in,
  // observed outputs
  input wire logic                 ion_path_en_out,
  input wire logic                 electron_path_en_out,
  input wire logic                 ramp_active_out,
  input wire logic                 hv_conversion_done_out,
  input wire logic                 write_strobe_out,
  input wire logic [6:0]           staged_bits_out,
  input wire logic                 fifo_full_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  // comparator falls in the conversion sector while ramping
  sequence s_flip;
    hv_in.comparator ##1 (!hv_in.comparator && ramp_active_out && timing_in.sector == sdc_pkg::SEC_10);
  endsequence
  a_path_select: assert property (ion_path_en_out == !hv_in.hv_polarity && electron_path_en_out == hv_in.hv_polarity)
    else $error("input path enable wrong");
  a_done_flip: assert property (s_flip |=> hv_conversion_done_out)
    else $error("done pulse missing");
  a_done_sector: assert property (hv_conversion_done_out |-> $past(timing_in.sector) == sdc_pkg::SEC_10)
    else $error("done pulse outside conversion sector");
  a_done_single: assert property (hv_conversion_done_out |=> !hv_conversion_done_out)
    else $error("done pulse too long");
  a_ramp_set: assert property (hv_in.hv_conversion_start && !timing_in.phase_one |=> ramp_active_out)
    else $error("ramp not started");
  a_ramp_clear: assert property (timing_in.phase_one |=> !ramp_active_out)
    else $error("ramp not cleared");
  a_zero_mute: assert property (hv_in.hv_zero |=> !write_strobe_out)
    else $error("strobe during hv zero");
  a_full_mute: assert property (fifo_full_out |=> !write_strobe_out)
    else $error("strobe while full");
  a_strobe_cause: assert property (write_strobe_out |-> $past(timing_in.phase_one) || $past(timing_in.phase_two))
    else $error("strobe without phase pulse");
  a_odd_quiet: assert property (timing_in.phase_one && !timing_in.phase_two
    && timing_in.sector[sdc_pkg::ODD_BIT] |=> !write_strobe_out)
    else $error("phase one strobe in odd sector");
  a_staged_hold: assert property (!timing_in.sector_end |=> $stable(staged_bits_out))
    else $error("staged bits moved");
endmodule // sdc_commutator_props
// attach the checker to the commutator
bind sdc_commutator sdc_commutator_props i_props (.ref_clk_in, .rst_in, .timing_in, .hv_in, .ion_path_en_out,
  .electron_path_en_out, .ramp_active_out, .hv_conversion_done_out, .write_strobe_out, .staged_bits_out, .fifo_full_out);

/* File: tb/sdc_commutator_tb.sv */
// self-checking bench for the sensor data commutator
`timescale 1ns/1ns
module sdc_commutator_tb;
  // drive bit positions: timing 20..6, hv 5..0
  localparam int P1 = 20, P2 = 19, CS = 18, BU = 17, FP = 16, FB = 15, SE = 14, AZ = 6;
  localparam int ST = 5, CMP = 4, POL = 3, HZ = 2, ADV = 1, BE = 0;
  logic        clk, ion, ele, ramp, done, stb, bval, bready, full, prdy, perr, er;
  logic        rst = 1'b1, stall = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [6:0]  staged, bdata, last;
  logic [11:0] paddr = '0;
  logic [20:0] drv = '0;
  logic [31:0] pwdata = '0, prdata, rd, want = '0;
  int          fails = 0, samples_checked = 0, nstb = 0, ndn = 0, cyc = 0, got, base;
  ////////////////////////////////////////
  sdc_commutator i_dut (.ref_clk_in(clk), .rst_in(rst), .timing_in(drv[20:6]), .hv_in(drv[5:0]),
    .ion_path_en_out(ion), .electron_path_en_out(ele), .ramp_active_out(ramp),
    .hv_conversion_done_out(done), .write_strobe_out(stb), .staged_bits_out(staged),
    .buf_valid_out(bval), .buf_ready_in(bready), .buf_data_out(bdata), .fifo_full_out(full),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready(prdy), .pslverr(perr));
  sdc_buf_model i_buf (.clk_in(clk), .rst_in(rst), .stall_in(stall), .valid_in(bval),
    .data_in(bdata), .ready_out(bready), .last_out(last), .count_out(got));
  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // strobe and done tallies, run ceiling
  always @(posedge clk)
  begin
    nstb <= nstb + int'(stb);
    ndn  <= ndn + int'(done);
    cyc  <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // one comparison
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // one apb transfer, then an idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = perr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // one-cycle pulse on a drive bit, then a quiet cycle
  task automatic pz(input int b);
    drv[b] <= 1'b1;
    @(posedge clk);
    drv[b] <= 1'b0;
    @(posedge clk);
  endtask
  // pulse, let the strobe land, compare the tally
  task automatic strobe(input int b, input logic e);
    pz(b);
    @(posedge clk);
    want += {31'h0, e};
    chk(nstb, want);
  endtask
  // one staging sequence with an optional mid clear
  task automatic stage(input int s, fb, n1, clr, n2, input logic [6:0] e);
    drv[13:7] <= s[6:0];
    drv[FB]   <= fb[0];
    pz(BU);
    pz(CS);
    repeat (n1) pz(BU);
    if (clr == CMP) pz(ST);
    if (clr != 0) pz(clr);
    repeat (2) @(posedge clk);
    repeat (n2) pz(BU);
    pz(SE);
    chk(staged, e);
  endtask
  // expected strobe per mode, sector and phase
  function automatic logic ex(input int m, s, p2);
    case (m)
      1: return p2 ? s % 5 == 0 : (s == 66 || s == 72 || s == 78);
      2: return p2 ? (s >= 2 && s <= 7 || s == 10) : (s == 2 || s == 10);
      default: return p2 && (s == 2 || s == 3);
    endcase
  endfunction
  // walk every sector in one scan mode
  task automatic sweep(input int m);
    apb(1'b1, sdc_pkg::CTRL_OFS, m);
    for (int s = 0; s < 128; s++)
    begin
      drv[13:7] <= s[6:0];
      drv[AZ]   <= (s % 5 == 0);
      strobe(P1, ex(m, s, 0));
      strobe(P2, ex(m, s, 1));
    end
  endtask
  // closing verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, sdc_pkg::CTRL_OFS, 0);
    chk(rd, 32'h0);
    apb(1'b1, sdc_pkg::CTRL_OFS, 32'hffffffff);
    apb(1'b0, sdc_pkg::CTRL_OFS, 0);
    chk(rd, 32'hf);
    apb(1'b0, 12'h010, 0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, sdc_pkg::CTRL_OFS, 0);
    drv[POL] <= 1'b1;
    repeat (2) @(posedge clk);
    chk({ion, ele}, 2'b01);
    stage(3, 0, 3, 0, 0, 7'h03);
    stage(5, 1, 4, 0, 0, 7'h00);
    stage(4, 0, 5, FP, 2, 7'h02);
    stage(7, 0, 100, 0, 0, 7'h64);
    stage(3, 0, 1, CMP, 2, 7'h03);
    chk(ndn, 0);
    stage(10, 0, 4, CMP, 5, 7'h05);
    chk(ndn, 1);
    pz(ST);
    chk(ramp, 1'b1);
    pz(P1);
    chk(ramp, 1'b0);
    sweep(1);
    sweep(2);
    pz(BE);
    apb(1'b0, sdc_pkg::STATUS_OFS, 0);
    chk(rd[3:2], 2'b11);
    sweep(4);
    drv[13:7] <= 7'h01;
    for (int k = 0; k < 4; k++)
    begin
      strobe(P2, k == 2);
      pz(ADV);
    end
    drv[13:7] <= 7'h02;
    drv[HZ]   <= 1'b1;
    apb(1'b1, sdc_pkg::CTRL_OFS, 32'h2);
    strobe(P2, 1'b0);
    drv[HZ]   <= 1'b0;
    apb(1'b1, sdc_pkg::CTRL_OFS, 32'ha);
    strobe(P2, 1'b0);
    drv[AZ]   <= 1'b0;
    apb(1'b1, sdc_pkg::CTRL_OFS, 32'h3);
    strobe(P2, 1'b0);
    apb(1'b1, sdc_pkg::CTRL_OFS, 32'h2);
    stall <= 1'b1;
    for (int k = 0; k < 10; k++)
    begin
      pz(SE);
      strobe(P2, k < 7);
    end
    chk(full, 1'b1);
    apb(1'b0, sdc_pkg::STATUS_OFS, 0);
    chk(rd[7:4], 4'h8);
    chk(rd[0], 1'b1);
    apb(1'b0, sdc_pkg::FIFO_OFS, 0);
    chk(rd[7:0], 8'h85);
    base = got;
    stall <= 1'b0;
    for (int i = 0; i < 100 && got < base + 8; i++)
      @(posedge clk);
    chk(got - base, 8);
    chk({bval, full, last}, 9'h005);
    apb(1'b1, sdc_pkg::STATUS_OFS, 32'h1);
    apb(1'b0, sdc_pkg::STATUS_OFS, 0);
    chk(rd[0], 1'b0);
    report_and_stop();
  end
endmodule // sdc_commutator_tb
